// [gpio_ports_five_six_pinmux.sv]
/*
  Port 5 and port 6 general I/O with pin multiplexing: pull-ups, bus
  open-drain pins, wake-up inputs and timer-shared pins.
  Assumes a register master on mclk and pins asynchronous to mclk;
  pad wires are resolved outside from output and enable signals.
*/
// Behaviour
// - Pull-up on when bit set, off cleared
// - Pull-up acts only on input pins
// - Pull-up bits 7,6 read zero, ignore writes
// - Bus enable, wake-up select, else direction
// - Bus clock pin is open-drain only
// - Bus data pin is open-drain only
// - Wake-up select overrides direction; pin55 triggers converter
// - Port 6 direction write-only, reset zero
// - Port 6 data drives general output pins
// - Data read returns stored bit for outputs
// - Data read returns pin level for inputs
// - Timer configuration beats port settings
// - Pin 67 general I/O, feeds timer capture
// - Port 6 registers act only as general port
// - Port 5 direction 1 output, 0 input
// - Bus enable overrides port on pins 57,56
`timescale 1ns/1ps
module gpio_ports_five_six_pinmux
  import gpio56_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_b,
  // Register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Serial bus block
  input  wire logic       bus_function_enable,
  input  wire logic       bus_clk_drive_low,
  input  wire logic       bus_data_drive_low,
  output logic            bus_clk_in,
  output logic            bus_data_in,
  // Timer block, pin 67 settings and signals
  input  wire logic       timer1_d_output_disable,
  input  wire logic [1:0] timer_combination_mode,
  input  wire logic       timer1_d_pulse_width_mode,
  input  wire logic [2:0] timer1_io_control_cd,
  input  wire logic       timer1_d_output,
  output logic            timer1_d_capture_in,
  // Wake-up and converter trigger
  output logic      [5:0] wakeup_in,
  output logic            converter_trigger_input,
  // Port 5 pads
  input  wire logic [7:0] port5_pin_in,
  output logic      [7:0] port5_pin_out,
  output logic      [7:0] port5_pin_oe,
  output logic      [5:0] port5_pullup_on,
  // Port 6 pads
  input  wire logic [7:0] port6_pin_in,
  output logic      [7:0] port6_pin_out,
  output logic      [7:0] port6_pin_oe
);
  import gpio56_pkg::*;

  logic [7:0] port5_pullup_control;
  logic [7:0] port5_direction;
  logic [7:0] port5_function_select;
  logic [7:0] port5_data;
  logic [7:0] port6_direction;
  logic [7:0] port6_output_data;
  logic [7:0] port5_sync;
  logic [7:0] port6_sync;
  logic       timer_owns_67;
  logic [7:0] p5_general;
  logic [7:0] p5_out_en;
  logic [7:0] next_rdata;
  logic       rd_hold;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Every pin level read by logic passes two flops first
  bit_sync #(.WIDTH(8)) u_sync5 (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .async_in (port5_pin_in),
    .sync_out (port5_sync)
  );

  bit_sync #(.WIDTH(8)) u_sync6 (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .async_in (port6_pin_in),
    .sync_out (port6_sync)
  );

  // ----------------------------------------------------------------
  // Timer ownership of pin 67
  // ----------------------------------------------------------------
  timer_pin_decode u_dec67 (
    .output_disable   (timer1_d_output_disable),
    .combination_mode (timer_combination_mode),
    .pulse_width_mode (timer1_d_pulse_width_mode),
    .io_field         (timer1_io_control_cd),
    .timer_owns       (timer_owns_67)
  );

  // ----------------------------------------------------------------
  // Port 5 registers
  // ----------------------------------------------------------------
  // Only the low six pull-up bits are storable
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      port5_pullup_control <= RST_BYTE;
    else if (reg_wr && reg_addr == OFS_PORT5_PULLUP)
      port5_pullup_control <= reg_wdata & PULLUP_WRITE_MASK;
  end

  // Direction, function select and data of port 5
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      port5_direction       <= RST_BYTE;
      port5_function_select <= RST_BYTE;
      port5_data            <= RST_BYTE;
    end
    else if (reg_wr)
    begin
      if (reg_addr == OFS_PORT5_DIR)
        port5_direction <= reg_wdata;
      if (reg_addr == OFS_PORT5_FUNC)
        port5_function_select <= reg_wdata;
      if (reg_addr == OFS_PORT5_DATA)
        port5_data <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Port 6 registers
  // ----------------------------------------------------------------
  // Direction is write-only; data stores output levels
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      port6_direction   <= RST_BYTE;
      port6_output_data <= RST_BYTE;
    end
    else if (reg_wr)
    begin
      if (reg_addr == OFS_PORT6_DIR)
        port6_direction <= reg_wdata;
      if (reg_addr == OFS_PORT6_DATA)
        port6_output_data <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Port 5 pin selection
  // ----------------------------------------------------------------
  // Which pins are general I/O: bus and wake-up take priority
  always_comb
  begin
    p5_general        = 8'hff;
    p5_general[5:0]   = ~port5_function_select[5:0];
    if (bus_function_enable)
    begin
      p5_general[BIT_BUS_CLK]  = 1'b0;
      p5_general[BIT_BUS_DATA] = 1'b0;
    end
  end

  // General pins drive when direction is 1
  assign p5_out_en = p5_general & port5_direction;

  // Pad drive: bus pins only pull low, never drive high
  always_comb
  begin
    port5_pin_out = port5_data;
    port5_pin_oe  = p5_out_en;
    if (bus_function_enable)
    begin
      port5_pin_out[BIT_BUS_CLK]  = 1'b0;
      port5_pin_oe[BIT_BUS_CLK]   = bus_clk_drive_low;
      port5_pin_out[BIT_BUS_DATA] = 1'b0;
      port5_pin_oe[BIT_BUS_DATA]  = bus_data_drive_low;
    end
  end

  // Pull-ups only where the direction bit says input
  // A wake-up pin left with direction 1 keeps its pull-up off, so that
  // software sees the same pull state whatever the pin function is
  assign port5_pullup_on = port5_pullup_control[5:0] & ~port5_direction[5:0];

  // Wake-up inputs, gated by their select bit
  assign wakeup_in = port5_sync[5:0] & port5_function_select[5:0];
  assign converter_trigger_input = wakeup_in[5];

  // Bus line levels back to the serial block
  assign bus_clk_in  = port5_sync[BIT_BUS_CLK];
  assign bus_data_in = port5_sync[BIT_BUS_DATA];

  // ----------------------------------------------------------------
  // Port 6 pin selection
  // ----------------------------------------------------------------
  // Timer overrides direction and data on pin 67
  always_comb
  begin
    port6_pin_out = port6_output_data;
    port6_pin_oe  = port6_direction;
    if (timer_owns_67)
    begin
      port6_pin_out[BIT_TIMER_PIN] = timer1_d_output;
      port6_pin_oe[BIT_TIMER_PIN]  = 1'b1;
    end
  end

  // Capture input always sees the synchronised pin level
  // It lags the pad by two cycles, like every other pin read
  assign timer1_d_capture_in = port6_sync[BIT_TIMER_PIN];

  // ----------------------------------------------------------------
  // Register read path
  // ----------------------------------------------------------------
  // Data reads mix stored bits and live levels by direction
  always_comb
  begin
    next_rdata = RST_BYTE;
    unique case (reg_addr)
      OFS_PORT5_PULLUP: next_rdata = port5_pullup_control;
      OFS_PORT5_FUNC:   next_rdata = port5_function_select;
      OFS_PORT5_DATA:   next_rdata = (port5_data & port5_direction)
                                   | (port5_sync & ~port5_direction);
      OFS_PORT6_DATA:   next_rdata = (port6_output_data & port6_direction)
                                   | (port6_sync & ~port6_direction);
      OFS_PORT5_PIN:    next_rdata = port5_sync;
      OFS_PORT6_PIN:    next_rdata = port6_sync;
      default:          next_rdata = RST_BYTE;  // Write-only and unmapped read zero
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reg_rdata <= RST_BYTE;
      rd_hold   <= 1'b0;
    end
    else
    begin
      rd_hold   <= reg_rd;
      reg_rdata <= reg_rd ? next_rdata : RST_BYTE;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_pullup_reserved: assert property (
    @(posedge mclk) disable iff (!rst_b)
    port5_pullup_control[7:6] == 2'h0)
    else $error("reserved pull-up bits set");

  a_pullup_write: assert property (
    @(posedge mclk) disable iff (!rst_b)
    reg_wr && reg_addr == OFS_PORT5_PULLUP
    |=> port5_pullup_control[5:0] == $past(reg_wdata[5:0]))
    else $error("pull-up write lost");

  a_pullup_output_off: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (port5_pin_oe[5:0] & port5_pullup_on) == 6'h0)
    else $error("pull-up on a driven pin");

  a_bus_clk_low: assert property (
    @(posedge mclk) disable iff (!rst_b)
    bus_function_enable && port5_pin_oe[BIT_BUS_CLK]
    |-> !port5_pin_out[BIT_BUS_CLK])
    else $error("bus clock driven high");

  a_bus_data_low: assert property (
    @(posedge mclk) disable iff (!rst_b)
    bus_function_enable |-> port5_pin_oe[BIT_BUS_DATA] == bus_data_drive_low
      && !port5_pin_out[BIT_BUS_DATA])
    else $error("bus data not open drain");

  a_wakeup_no_drive: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (port5_function_select[5:0] & port5_pin_oe[5:0]) == 6'h0)
    else $error("wake-up pin driven");

  a_data_read: assert property (
    @(posedge mclk) disable iff (!rst_b)
    reg_rd && reg_addr == OFS_PORT6_DATA && !reg_wr
    |=> ((reg_rdata ^ $past(port6_output_data)) & $past(port6_direction)) == 8'h00)
    else $error("stored bit not read back");

  a_timer_wins: assert property (
    @(posedge mclk) disable iff (!rst_b)
    timer_owns_67 |-> port6_pin_oe[BIT_TIMER_PIN]
      && port6_pin_out[BIT_TIMER_PIN] == timer1_d_output)
    else $error("timer not driving pin 67");

  a_general_p6: assert property (
    @(posedge mclk) disable iff (!rst_b)
    port6_pin_oe[6:0] == port6_direction[6:0])
    else $error("port 6 enable wrong");

  a_pullup_dir_off: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (port5_direction[5:0] & port5_pullup_on) == 6'h0)
    else $error("pull-up on a pin set as output");

  a_general_p5: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !bus_function_enable |-> port5_pin_oe[7:6] == port5_direction[7:6])
    else $error("port 5 enable not from direction");

  a_bus_override: assert property (
    @(posedge mclk) disable iff (!rst_b)
    bus_function_enable |-> port5_pin_oe[BIT_BUS_CLK] == bus_clk_drive_low)
    else $error("bus clock pin not owned by bus");

  a_timer_off: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !timer_owns_67 |-> port6_pin_oe[BIT_TIMER_PIN] == port6_direction[BIT_TIMER_PIN]
      && port6_pin_out[BIT_TIMER_PIN] == port6_output_data[BIT_TIMER_PIN])
    else $error("pin 67 not general while timer idle");

  a_live_read: assert property (
    @(posedge mclk) disable iff (!rst_b)
    reg_rd && reg_addr == OFS_PORT6_DATA
    |=> ((reg_rdata ^ $past(port6_sync)) & ~$past(port6_direction)) == 8'h00)
    else $error("pin level not read back");

  a_dir_write_only: assert property (
    @(posedge mclk) disable iff (!rst_b)
    reg_rd && reg_addr == OFS_PORT6_DIR |=> reg_rdata == RST_BYTE)
    else $error("write-only direction readable");

  a_rdata_idle: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !rd_hold |-> reg_rdata == RST_BYTE)
    else $error("read data outside read cycle");
endmodule : gpio_ports_five_six_pinmux

// [gpio56_pkg.sv]
/*
  Package for the port 5 / port 6 pin block: register offsets, reset
  values, field positions and timer mode codes.
  Assumes a plain strobe register port with 8-bit data.
*/
package gpio56_pkg;
  // ----------------------------------------------------------------
  // Register offsets (byte addresses on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_PORT5_PULLUP   = 4'h0;
  localparam logic [3:0] OFS_PORT5_DIR      = 4'h1;
  localparam logic [3:0] OFS_PORT5_FUNC     = 4'h2;
  localparam logic [3:0] OFS_PORT6_DIR      = 4'h3;
  localparam logic [3:0] OFS_PORT6_DATA     = 4'h4;
  localparam logic [3:0] OFS_PORT5_DATA     = 4'h5;
  localparam logic [3:0] OFS_PORT5_PIN      = 4'h6;
  localparam logic [3:0] OFS_PORT6_PIN      = 4'h7;

  // ----------------------------------------------------------------
  // Reset values and field layout
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE           = 8'h00;
  localparam logic [7:0] PULLUP_WRITE_MASK  = 8'h3f;
  localparam int         BIT_BUS_CLK        = 7;
  localparam int         BIT_BUS_DATA       = 6;
  localparam int         BIT_TIMER_PIN      = 7;
  localparam logic [1:0] CMB_MODE_NORMAL    = 2'h0;
  localparam int         SYNC_STAGES        = 2;
endpackage : gpio56_pkg

// [bit_sync.sv]
/*
  Two-stage synchroniser for a vector of pin levels.
  Assumes inputs are asynchronous to mclk.
*/
`timescale 1ns/1ps
module bit_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             mclk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  // ----------------------------------------------------------------
  // First stage is read only by the second
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stage1   <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : bit_sync

// [timer_pin_decode.sv]
/*
  Decides whether a timer-shared port 6 pin is driven by the timer.
  Assumes timer settings are levels on the same clock as this block.
*/
`timescale 1ns/1ps
module timer_pin_decode
  import gpio56_pkg::*;
(
  input  wire logic       output_disable,
  input  wire logic [1:0] combination_mode,
  input  wire logic       pulse_width_mode,
  input  wire logic [2:0] io_field,
  output logic            timer_owns
);
  // ----------------------------------------------------------------
  // Timer output wins only while its output is enabled
  // ----------------------------------------------------------------
  always_comb
  begin
    timer_owns = 1'b0;
    if (!output_disable)
    begin
      // Field 001 or 01X selects a compare output
      if ((io_field == 3'h1) || (io_field[2:1] == 2'h1))
        timer_owns = 1'b1;
      if (pulse_width_mode)
        timer_owns = 1'b1;
      if (combination_mode != CMB_MODE_NORMAL)
        timer_owns = 1'b1;
    end
  end
endmodule : timer_pin_decode

// [pin_world.sv]
/*
  Model of the outside world at the pads of ports 5 and 6.
  Assumes the bench sets the external drive levels in ext5 and ext6.
*/
`timescale 1ns/1ps
module pin_world (
  input  wire logic [7:0] port5_pin_out,
  input  wire logic [7:0] port5_pin_oe,
  input  wire logic [7:0] port6_pin_out,
  input  wire logic [7:0] port6_pin_oe,
  input  wire logic [7:0] ext5,
  input  wire logic [7:0] ext6,
  output logic      [7:0] port5_lvl,
  output logic      [7:0] port6_lvl
);
  // ----------------------------------------------------------------
  // Pad resolution
  // ----------------------------------------------------------------
  // A driven pad wins; ext5[7:6] stand for the bus pull-ups and stay high
  always_comb
  begin
    port5_lvl = (port5_pin_oe & port5_pin_out) | (~port5_pin_oe & ext5);
    port6_lvl = (port6_pin_oe & port6_pin_out) | (~port6_pin_oe & ext6);
  end
endmodule : pin_world

// [test_gpio_ports_five_six_pinmux.sv]
/*
  Self-checking bench for the port 5 / port 6 pin block.
  Assumes pin_world models the pads and the register port never waits.
*/
`timescale 1ns/1ps
module test_gpio_ports_five_six_pinmux;
  import gpio56_pkg::*;
  logic       mclk, rst_b, reg_wr, reg_rd, bus_en, clk_low, data_low;
  logic       t_dis, t_pwm, t_out, bus_clk_in, bus_data_in, cap_in, trig;
  logic [1:0] t_cmb;
  logic [2:0] t_io;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, ext5, ext6, p5_lvl, p6_lvl, rd_val;
  logic [7:0] p5_out, p5_oe, p6_out, p6_oe;
  logic [5:0] wake, pull;
  int         n_fail, comparisons;

  gpio_ports_five_six_pinmux DUT (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .bus_function_enable(bus_en), .bus_clk_drive_low(clk_low),
    .bus_data_drive_low(data_low), .bus_clk_in(bus_clk_in), .bus_data_in(bus_data_in),
    .timer1_d_output_disable(t_dis), .timer_combination_mode(t_cmb),
    .timer1_d_pulse_width_mode(t_pwm), .timer1_io_control_cd(t_io),
    .timer1_d_output(t_out), .timer1_d_capture_in(cap_in), .wakeup_in(wake),
    .converter_trigger_input(trig), .port5_pin_in(p5_lvl), .port5_pin_out(p5_out),
    .port5_pin_oe(p5_oe), .port5_pullup_on(pull), .port6_pin_in(p6_lvl),
    .port6_pin_out(p6_out), .port6_pin_oe(p6_oe));
  pin_world pads (.port5_pin_out(p5_out), .port5_pin_oe(p5_oe), .port6_pin_out(p6_out),
    .port6_pin_oe(p6_oe), .ext5(ext5), .ext6(ext6), .port5_lvl(p5_lvl),
    .port6_lvl(p6_lvl));

  // ----------------------------------------------------------------
  // Clock, bus tasks and checking
  // ----------------------------------------------------------------
  initial
  begin
    mclk = 1'h0;
    forever #10 mclk = ~mclk;
  end

  task check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      n_fail++;
    end
  endtask : check

  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'h1;
    @(posedge mclk);
    reg_wr    <= 1'h0;
    #1;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task rd(input logic [3:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge mclk);
    reg_rd   <= 1'h0;
    #1 rd_val = reg_rdata;
  endtask : rd

  // Pin levels cross two flops before they are seen
  task settle;
    repeat (3) @(posedge mclk);
    #1;
  endtask : settle

  task results;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task reset_state;
    check(pull, 8'h00);
    check(p6_oe, 8'h00);
    rd(OFS_PORT6_DIR);
    check(rd_val, 8'h00);
    rd(4'h9);
    check(rd_val, 8'h00);
  endtask : reset_state

  task pullups;
    wr(OFS_PORT5_PULLUP, 8'hff);
    rd(OFS_PORT5_PULLUP);
    check(rd_val, 8'h3f);
    check({2'h0, pull}, 8'h3f);
    wr(OFS_PORT5_DIR, 8'h05);
    check({2'h0, pull}, 8'h3a);
    check(p5_oe, 8'h05);
    wr(OFS_PORT5_PULLUP, 8'h00);
    check({2'h0, pull}, 8'h00);
  endtask : pullups

  // Wake-up select overrides an output direction on the same pin
  task wakeups;
    wr(OFS_PORT5_DIR, 8'h21);
    wr(OFS_PORT5_FUNC, 8'h21);
    ext5 <= 8'he1;
    settle();
    check(p5_oe & 8'h21, 8'h00);
    check({2'h0, wake}, 8'h21);
    check({7'h0, trig}, 8'h01);
    rd(OFS_PORT5_FUNC);
    check(rd_val, 8'h21);
    wr(OFS_PORT5_PULLUP, 8'h3f);
    check({2'h0, pull}, 8'h1e);
    ext5 <= 8'hc0;
    settle();
    check({7'h0, trig}, 8'h00);
    wr(OFS_PORT5_FUNC, 8'h00);
    wr(OFS_PORT5_DATA, 8'h01);
    check(p5_oe, 8'h21);
    check(p5_out & 8'h21, 8'h01);
    settle();
    rd(OFS_PORT5_DATA);
    check(rd_val, 8'hc1);
    rd(OFS_PORT5_PIN);
    check(rd_val, 8'hc1);
  endtask : wakeups

  // Bus pins only ever pull low or let go, whatever the direction says
  task bus_pins;
    wr(OFS_PORT5_DIR, 8'hc0);
    for (int k = 0; k < 4; k++)
    begin
      @(posedge mclk);
      bus_en   <= 1'h1;
      clk_low  <= k[1];
      data_low <= k[0];
      settle();
      check(p5_out & 8'hc0, 8'h00);
      check({6'h0, p5_oe[7:6]}, {6'h0, k[1:0]});
      check({6'h0, bus_clk_in, bus_data_in}, {6'h0, ~k[1], ~k[0]});
    end
    @(posedge mclk);
    bus_en <= 1'h0;
  endtask : bus_pins

  task port6_io;
    ext6 <= 8'h3c;
    wr(OFS_PORT6_DIR, 8'hf0);
    wr(OFS_PORT6_DATA, 8'ha5);
    check(p6_oe, 8'hf0);
    check(p6_out & 8'hf0, 8'ha0);
    settle();
    rd(OFS_PORT6_DATA);
    check(rd_val & 8'hf0, 8'ha0);
    check(rd_val & 8'h0f, 8'h0c);
    rd(OFS_PORT6_PIN);
    check(rd_val, 8'hac);
  endtask : port6_io

  // Each entry: disable, combination mode, pulse mode, io field, timer owns
  task timer_pin;
    logic [7:0] tbl [8];
    tbl = '{8'h80, 8'h88, 8'h03, 8'h05, 8'h00, 8'h11, 8'h41, 8'ha2};
    // Pass 0 with pin 67 set as output, pass 1 with it set as input
    for (int d = 0; d < 2; d++)
    begin
      wr(OFS_PORT6_DIR, d ? 8'h70 : 8'hf0);
      for (int k = 0; k < 8; k++)
      begin
        @(posedge mclk);
        {t_dis, t_cmb, t_pwm, t_io} <= tbl[k][7:1];
        #1;
        check({7'h0, p6_oe[7]}, {7'h0, tbl[k][0] | (d == 0)});
        check({7'h0, p6_out[7]}, {7'h0, ~tbl[k][0]});
      end
    end
    wr(OFS_PORT6_DIR, 8'hf0);
    settle();
    check({7'h0, cap_in}, 8'h01);
    // Timer drives 0 on pin 67 while the stored bit is 1
    @(posedge mclk);
    t_dis <= 1'h0;
    settle();
    rd(OFS_PORT6_DATA);
    check(rd_val, 8'hac);
    check({7'h0, cap_in}, 8'h00);
    @(posedge mclk);
    t_dis <= 1'h1;
    wr(OFS_PORT6_DIR, 8'h00);
    ext6 <= 8'h80;
    settle();
    check({7'h0, cap_in}, 8'h01);
    rd(OFS_PORT6_DATA);
    check(rd_val, 8'h80);
  endtask : timer_pin

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    n_fail = 0;
    comparisons = 0;
    {rst_b, reg_wr, reg_rd, bus_en, clk_low, data_low, t_pwm, t_out} = 8'h00;
    t_dis = 1'h1;
    t_cmb = 2'h0;
    t_io = 3'h0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    ext5 = 8'hc0;
    ext6 = 8'h00;
    repeat (6) @(posedge mclk);
    rst_b <= 1'h1;
    reset_state();
    pullups();
    wakeups();
    bus_pins();
    port6_io();
    timer_pin();
    results();
  end

  initial
  begin
    repeat (5000) @(posedge mclk);
    n_fail++;
    results();
  end
endmodule : test_gpio_ports_five_six_pinmux
